/* hw/fid_pkg.sv */
// Package for the fourteen-bit instruction decoder.
// Assumes four clocks, one per phase, per instruction cycle.
package fid_pkg;

   // Instruction word layout.
   localparam int WORD_W    = 14;
   localparam int FILE_W    = 7;
   localparam int BIT_W     = 3;
   localparam int LIT_W     = 8;
   localparam int JUMP_W    = 11;
   localparam int PHASES    = 4;
   localparam int CLASS_LSB = 12;
   localparam int DEST_POS  = 7;
   localparam int BSEL_LSB  = 7;
   localparam int JSEL_POS  = 11;

   // Instruction classes held in the top two bits.
   localparam logic [1:0] CLASS_BYTE = 2'h0;
   localparam logic [1:0] CLASS_BIT  = 2'h1;
   localparam logic [1:0] CLASS_JUMP = 2'h2;
   localparam logic [1:0] CLASS_LIT  = 2'h3;

   // Fixed control words with no operand.
   localparam logic [13:0] WORD_RETURN = 14'h0008;
   localparam logic [13:0] WORD_RETFIE = 14'h0009;
   localparam logic [13:0] WORD_SLEEP  = 14'h0063;
   localparam logic [13:0] WORD_WDCLR  = 14'h0064;

   // Byte operation codes in bits 11:8.
   localparam logic [3:0] BOP_MOVWF  = 4'h0;
   localparam logic [3:0] BOP_CLR    = 4'h1;
   localparam logic [3:0] BOP_DECFSZ = 4'hb;
   localparam logic [3:0] BOP_INCFSZ = 4'hf;

   // Bit operation codes in bits 11:10.
   localparam logic [1:0] BITOP_SKIPCLR = 2'h2;
   localparam logic [1:0] BITOP_SKIPSET = 2'h3;

   // Literal operation codes in bits 11:10.
   localparam logic [1:0] LOP_RETLW_HI = 2'h1;

   // Phase counter values.
   localparam logic [1:0] PH_Q1 = 2'h0;
   localparam logic [1:0] PH_Q2 = 2'h1;
   localparam logic [1:0] PH_Q3 = 2'h2;
   localparam logic [1:0] PH_Q4 = 2'h3;

   // Cycle kind: normal execute or forced no-operation.
   typedef enum logic [1:0] {
      ST_EXEC  = 2'b01,
      ST_FLUSH = 2'b10
   } fid_state_t;

   // Decoded fields sent to the datapath.
   typedef struct packed {
      logic [1:0]  opClass;
      logic [3:0]  opCode;
      logic [6:0]  fileIndex;
      logic        destFile;
      logic [2:0]  bitSel;
      logic [7:0]  literal;
      logic [10:0] jumpTarget;
      logic        usesFile;
      logic        isFlush;
   } fid_fields_t;

   // Datapath strobes for the current phase.
   typedef struct packed {
      logic fileRead;
      logic fileWrite;
      logic accWrite;
      logic fetchNext;
      logic pcLoad;
      logic pcReturn;
      logic cycleEnd;
   } fid_strobe_t;

   // Whole module state.
   typedef struct packed {
      fid_state_t  state;
      logic [1:0]  phase;
      fid_fields_t fields;
      fid_strobe_t strobe;
      logic [7:0]  readValue;
      logic        twoCycle;
   } fid_regs_t;

endpackage

/* hw/fid_decoder.sv */
// Instruction decoder and phase sequencer for a fourteen-bit core.
// Assumes the fetch stage holds a word valid at phase four and the datapath
// answers file reads with pin levels for port registers, in the same phase.
// Notes on behaviour
// - Word is opcode plus operand fields.
// - Destination bit zero writes accumulator, one file.
// - Seven-bit file index, range zero to 7f.
// - Three-bit field picks one of eight bits.
// - Literal is eight bits, jump target eleven.
// - Four oscillator periods form one cycle.
// - Branch or true skip adds no-op cycle.
// - File operand always read before write-back.
// - Don't-care bits never change the decode.
// - Port read-back uses pin levels, not latches.
`timescale 1ns/1ps
module fid_decoder (
   // Clock and reset.
   input  wire logic                clk,
   input  wire logic                reset_n,
   // Fetch side.
   input  wire logic [13:0]         instrWord,
   // Datapath feedback.
   input  wire logic [7:0]          fileData,
   input  wire logic                fileIsPort,
   input  wire logic [7:0]          pinLevels,
   input  wire logic                resultZero,
   // Decoded fields and strobes.
   output fid_pkg::fid_fields_t     fields,
   output fid_pkg::fid_strobe_t     strobe,
   output logic [7:0]               readValue,
   output logic [1:0]               phase
);

   fid_pkg::fid_regs_t r;
   fid_pkg::fid_regs_t next_r;
   logic [1:0]  wClass;
   logic [3:0]  wCode;
   logic        fixedWord;
   logic        skipTrue;

   ////////////////////////////////////////////////////////////////////////////
   // Word splitting, taken fresh from the fetch stage.
   assign wClass = instrWord[fid_pkg::CLASS_LSB +: 2];
   assign wCode  = instrWord[fid_pkg::DEST_POS + 1 +: 4];
   assign fixedWord = (instrWord == fid_pkg::WORD_RETURN) ||
                      (instrWord == fid_pkg::WORD_RETFIE);

   // A skip is true when the tested bit matches or the count reached zero.
   always_comb begin
      skipTrue = 1'b0;
      if (r.fields.opClass == fid_pkg::CLASS_BIT) begin
         if (r.fields.opCode[3:2] == fid_pkg::BITOP_SKIPCLR) begin
            skipTrue = ~r.readValue[r.fields.bitSel];
         end else if (r.fields.opCode[3:2] == fid_pkg::BITOP_SKIPSET) begin
            skipTrue = r.readValue[r.fields.bitSel];
         end
      end else if (r.fields.opClass == fid_pkg::CLASS_BYTE &&
                   (r.fields.opCode == fid_pkg::BOP_DECFSZ ||
                    r.fields.opCode == fid_pkg::BOP_INCFSZ)) begin
         skipTrue = resultZero;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Next state: phase count, decode at phase four, strobes per phase.
   always_comb begin
      next_r = r;
      next_r.strobe = '0;
      next_r.phase = r.phase + 2'h1;
      case (r.phase)
         fid_pkg::PH_Q4: begin
            next_r.strobe.fetchNext = 1'b1;
            if (r.state == fid_pkg::ST_EXEC && r.twoCycle) begin
               next_r.state = fid_pkg::ST_FLUSH;
               next_r.fields.isFlush = 1'b1;
               next_r.fields.usesFile = 1'b0;
            end else begin
               next_r.state = fid_pkg::ST_EXEC;
               next_r.fields.isFlush = 1'b0;
               next_r.fields.opClass = wClass;
               next_r.fields.opCode = wCode;
               next_r.fields.fileIndex = instrWord[fid_pkg::FILE_W-1:0];
               next_r.fields.destFile = instrWord[fid_pkg::DEST_POS];
               next_r.fields.bitSel = instrWord[fid_pkg::BSEL_LSB +: fid_pkg::BIT_W];
               next_r.fields.literal = instrWord[fid_pkg::LIT_W-1:0];
               next_r.fields.jumpTarget = instrWord[fid_pkg::JUMP_W-1:0];
               // Only class, byte opcode and destination bit pick file use; x bits never do.
               next_r.fields.usesFile = (wClass == fid_pkg::CLASS_BIT) ||
                  (wClass == fid_pkg::CLASS_BYTE &&
                   (wCode != fid_pkg::BOP_MOVWF || instrWord[fid_pkg::DEST_POS]) &&
                   !(wCode == fid_pkg::BOP_CLR && !instrWord[fid_pkg::DEST_POS]));
               next_r.twoCycle = (wClass == fid_pkg::CLASS_JUMP) || fixedWord ||
                  (wClass == fid_pkg::CLASS_LIT &&
                   wCode[3:2] == fid_pkg::LOP_RETLW_HI);
            end
         end
         fid_pkg::PH_Q1: begin
            next_r.strobe.fileRead = r.fields.usesFile;
         end
         fid_pkg::PH_Q2: begin
            if (r.fields.usesFile) begin
               next_r.readValue = fileIsPort ? pinLevels : fileData;
            end
         end
         default: begin
            // Phase three: write back, and a true skip makes a flush cycle.
            next_r.strobe.cycleEnd = 1'b1;
            if (r.state == fid_pkg::ST_EXEC) begin
               if (r.fields.opClass == fid_pkg::CLASS_BYTE ||
                   r.fields.opClass == fid_pkg::CLASS_BIT) begin
                  next_r.strobe.fileWrite = r.fields.usesFile &&
                     (r.fields.opClass == fid_pkg::CLASS_BIT ?
                      !r.fields.opCode[3] : r.fields.destFile);
                  next_r.strobe.accWrite = r.fields.opClass == fid_pkg::CLASS_BYTE &&
                     !r.fields.destFile && !fixedDecoded(r.fields);
                  // Return words sit in the byte class; they leave by the stack.
                  next_r.strobe.pcReturn = r.fields.opClass == fid_pkg::CLASS_BYTE &&
                     r.twoCycle && fixedDecoded(r.fields);
                  if (skipTrue) begin
                     next_r.twoCycle = 1'b1;
                  end
               end else if (r.fields.opClass == fid_pkg::CLASS_LIT) begin
                  next_r.strobe.accWrite = 1'b1;
                  next_r.strobe.pcReturn = r.twoCycle;
               end else begin
                  next_r.strobe.pcLoad = 1'b1;
               end
            end
         end
      endcase
   end

   // Byte-class words with no file and no result: nop, return and friends.
   function automatic logic fixedDecoded(input fid_pkg::fid_fields_t f);
      fixedDecoded = f.opCode == fid_pkg::BOP_MOVWF && !f.destFile;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // State register.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         r <= '{state: fid_pkg::ST_EXEC, phase: fid_pkg::PH_Q4, default: '0};
      end else begin
         r <= next_r;
      end
   end

   assign fields    = r.fields;
   assign strobe    = r.strobe;
   assign readValue = r.readValue;
   assign phase     = r.phase;

   ////////////////////////////////////////////////////////////////////////////
   // Checks on the sequencer.
   a_cycle_four: assert property (@(posedge clk) disable iff (!reset_n)
      strobe.fetchNext |=> !strobe.fetchNext [*3] ##1 strobe.fetchNext)
      else $error("Fetch not every four clocks.");
   a_flush_after: assert property (@(posedge clk) disable iff (!reset_n)
      (r.state == fid_pkg::ST_EXEC && phase == fid_pkg::PH_Q4 && r.twoCycle)
      |=> r.fields.isFlush)
      else $error("Two-cycle word not followed by flush.");
   a_flush_quiet: assert property (@(posedge clk) disable iff (!reset_n)
      r.fields.isFlush |-> !strobe.fileWrite && !strobe.accWrite && !strobe.pcLoad)
      else $error("Flush cycle had side effects.");
   a_read_first: assert property (@(posedge clk) disable iff (!reset_n)
      strobe.fileWrite |-> $past(strobe.fileRead, 2))
      else $error("File written without prior read.");
   a_dest_route: assert property (@(posedge clk) disable iff (!reset_n)
      (strobe.accWrite && fields.opClass == fid_pkg::CLASS_BYTE) |-> !fields.destFile)
      else $error("Accumulator write with file destination.");
   a_port_pins: assert property (@(posedge clk) disable iff (!reset_n)
      (phase == fid_pkg::PH_Q2 && fields.usesFile && fileIsPort) |=> readValue == $past(pinLevels))
      else $error("Port read did not use pins.");
   a_file_index: assert property (@(posedge clk) disable iff (!reset_n)
      $rose(phase == fid_pkg::PH_Q1) && !fields.isFlush |->
      fields.fileIndex == $past(instrWord[6:0]))
      else $error("File index not taken from low bits.");
   a_literal_jump: assert property (@(posedge clk) disable iff (!reset_n)
      $rose(phase == fid_pkg::PH_Q1) && !fields.isFlush |->
      fields.literal == $past(instrWord[7:0]) && fields.jumpTarget == $past(instrWord[10:0]))
      else $error("Literal or target split wrong.");
   // The bit select is split from the word like the other operand fields.
   a_bit_select: assert property (@(posedge clk) disable iff (!reset_n)
      $rose(phase == fid_pkg::PH_Q1) && !fields.isFlush |->
      fields.bitSel == $past(instrWord[fid_pkg::BSEL_LSB +: fid_pkg::BIT_W]))
      else $error("Bit select split wrong.");
   // Each strobe keeps to its own phase, so the datapath can rely on it.
   a_fetch_phase: assert property (@(posedge clk) disable iff (!reset_n)
      strobe.fetchNext |-> phase == fid_pkg::PH_Q1)
      else $error("Fetch strobe outside phase one.");
   a_read_phase: assert property (@(posedge clk) disable iff (!reset_n)
      strobe.fileRead |-> phase == fid_pkg::PH_Q2)
      else $error("File read outside phase two.");
   a_write_phase: assert property (@(posedge clk) disable iff (!reset_n)
      (strobe.fileWrite || strobe.accWrite) |-> phase == fid_pkg::PH_Q4 && strobe.cycleEnd)
      else $error("Write strobe outside phase four.");
   // Any word that names a file register reads it, even a pure write.
   a_rmw_read: assert property (@(posedge clk) disable iff (!reset_n)
      (phase == fid_pkg::PH_Q1 && fields.usesFile) |=> strobe.fileRead)
      else $error("File operand not read.");
   // A byte result with the file destination goes back to the file.
   a_dest_file: assert property (@(posedge clk) disable iff (!reset_n)
      (phase == fid_pkg::PH_Q3 && r.state == fid_pkg::ST_EXEC && fields.usesFile &&
       fields.opClass == fid_pkg::CLASS_BYTE && fields.destFile) |=> strobe.fileWrite)
      else $error("File destination not written.");
   // A return changes the program counter, so an idle cycle must follow.
   a_return_pc: assert property (@(posedge clk) disable iff (!reset_n)
      strobe.pcReturn |=> r.fields.isFlush)
      else $error("Return not followed by flush.");
   // The literal class always loads the accumulator and never a file.
   a_lit_acc: assert property (@(posedge clk) disable iff (!reset_n)
      (strobe.cycleEnd && !fields.isFlush && fields.opClass == fid_pkg::CLASS_LIT) |->
      strobe.accWrite && !strobe.fileWrite)
      else $error("Literal result not steered to accumulator.");
   // Main scenarios: bit skip, jump, port read-back, return and zero skip.
   c_skip_taken: cover property (@(posedge clk) disable iff (!reset_n)
      fields.isFlush && fields.opClass == fid_pkg::CLASS_BIT);
   c_jump: cover property (@(posedge clk) disable iff (!reset_n) strobe.pcLoad);
   c_port_rmw: cover property (@(posedge clk) disable iff (!reset_n)
      strobe.fileWrite && fileIsPort);
   c_return: cover property (@(posedge clk) disable iff (!reset_n) strobe.pcReturn);
   c_byte_flush: cover property (@(posedge clk) disable iff (!reset_n)
      fields.isFlush && fields.opClass == fid_pkg::CLASS_BYTE);

endmodule

/* bench/fid_partner.sv */
// Fetch stage and datapath model facing the instruction decoder.
// Assumes the bench sets the next word and the operand values.
`timescale 1ns/1ps
module fid_partner (
   // Clock and reset.
   input  wire logic                 clk,
   input  wire logic                 reset_n,
   // Decoder side.
   input  wire fid_pkg::fid_strobe_t strobe,
   input  wire logic [1:0]           phase,
   // Bench side.
   input  wire logic [13:0]          loadWord,
   input  wire logic [7:0]           regValue,
   input  wire logic [7:0]           pinValue,
   input  wire logic                 portSel,
   input  wire logic                 zeroSel,
   // Answers to the decoder.
   output logic [13:0]               instrWord,
   output logic [7:0]                fileData,
   output logic                      fileIsPort,
   output logic [7:0]                pinLevels,
   output logic                      resultZero
);
   ////////////////////////////////////////////////////////////////////////////
   // The next word is fetched during the third phase, so it is steady when taken.
   always_ff @(posedge clk) begin
      if (!reset_n || phase == 2'h2) begin
         instrWord <= loadWord;
      end
   end
   // Read data is only shown while the read strobe stands; otherwise it is garbage.
   assign fileData   = strobe.fileRead ? regValue : ~regValue;
   assign fileIsPort = portSel;
   assign pinLevels  = pinValue;
   // The zero result only means something in the third phase.
   assign resultZero = (phase == 2'h2) ? zeroSel : ~zeroSel;
endmodule

/* bench/tb_fid_decoder.sv */
// Self-checking bench for the instruction decoder.
// Assumes the partner model supplies words and operand data.
`timescale 1ns/1ps
module tb_fid_decoder;
   // Stimulus, observed outputs and captured results.
   logic                 clk      = 1'b0;
   logic                 reset_n  = 1'b0;
   logic [13:0]          loadWord = 14'h0000;
   logic [7:0]           regValue = 8'h00;
   logic [7:0]           pinValue = 8'h00;
   logic                 portSel  = 1'b0;
   logic                 zeroSel  = 1'b0;
   logic [13:0]          instrWord;
   logic [7:0]           fileData;
   logic [7:0]           pinLevels;
   logic [7:0]           readValue;
   logic [7:0]           rv;
   logic                 fileIsPort;
   logic                 resultZero;
   logic                 flushNext;
   logic [1:0]           phase;
   fid_pkg::fid_fields_t fields;
   fid_pkg::fid_fields_t fd;
   fid_pkg::fid_strobe_t strobe;
   fid_pkg::fid_strobe_t acc;
   fid_pkg::fid_strobe_t flushAcc;
   int                   error_cnt = 0;
   int                   checked   = 0;
   ////////////////////////////////////////////////////////////////////////////
   // Device under test and its far side.
   fid_decoder fid_decoder_i (.clk(clk), .reset_n(reset_n), .instrWord(instrWord),
      .fileData(fileData), .fileIsPort(fileIsPort), .pinLevels(pinLevels),
      .resultZero(resultZero), .fields(fields), .strobe(strobe),
      .readValue(readValue), .phase(phase));
   fid_partner fid_partner_i (.clk(clk), .reset_n(reset_n), .strobe(strobe), .phase(phase),
      .loadWord(loadWord), .regValue(regValue), .pinValue(pinValue), .portSel(portSel),
      .zeroSel(zeroSel), .instrWord(instrWord), .fileData(fileData),
      .fileIsPort(fileIsPort), .pinLevels(pinLevels), .resultZero(resultZero));
   // Free-running oscillator.
   always #12.5 clk = ~clk;
   ////////////////////////////////////////////////////////////////////////////
   // Verdict and compare helpers.
   task automatic tally_and_finish();
      if (error_cnt == 0 && checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic cmpVal(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
         error_cnt++;
      end
   endtask
   task automatic cmpFlag(input logic got, input logic exp);
      cmpVal(16'(got), 16'(exp));
   endtask
   // Issues one word, then records its cycle and the cycle after it.
   task automatic run(input logic [13:0] w, input logic [7:0] r, input logic [7:0] p,
                      input logic port, input logic z);
      bit seen;
      int n;
      seen = 1'b0;
      @(posedge clk);
      loadWord <= w;
      regValue <= r;
      pinValue <= p;
      portSel  <= port;
      zeroSel  <= z;
      for (n = 0; n < 24; n++) begin
         @(posedge clk);
         #1;
         if (seen && phase == 2'h0 && fields.isFlush === 1'b0) break;
         if (phase == 2'h3) seen = 1'b1;
      end
      if (n == 24) begin
         error_cnt++;
         tally_and_finish();
      end
      fd = fields;
      cmpFlag(strobe.fetchNext, 1'b1);
      acc = '0;
      for (n = 1; n < 4; n++) begin
         @(posedge clk);
         #1;
         cmpVal(16'(phase), 16'(n));
         acc = acc | strobe;
      end
      rv = readValue;
      @(posedge clk);
      #1;
      flushNext = fields.isFlush;
      flushAcc = '0;
      repeat (3) begin
         @(posedge clk);
         #1;
         flushAcc = flushAcc | strobe;
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // Byte operations: destination steering, index extremes and the read.
   task automatic tByte();
      for (int d = 0; d < 2; d++) begin
         run(14'h0700 | 14'(d * 16'h00ff), 8'h3c, 8'hc3, 1'b0, 1'b0);
         cmpVal(16'(fd.fileIndex), d ? 16'h007f : 16'h0000);
         cmpVal(16'(fd.opCode), 16'h0007);
         cmpFlag(acc.accWrite, d == 0);
         cmpFlag(acc.fileWrite, d == 1);
         cmpFlag(acc.fileRead, 1'b1);
         cmpVal(16'(rv), 16'h003c);
         cmpFlag(fd.destFile, d[0]);
         cmpFlag(fd.usesFile, 1'b1);
         cmpFlag(acc.cycleEnd, 1'b1);
      end
      run(14'h01a5, 8'h5a, 8'ha5, 1'b0, 1'b0);
      cmpFlag(acc.fileRead & acc.fileWrite, 1'b1);
      // Accumulator clear with every ignored bit set names no file.
      run(14'h017f, 8'h5a, 8'ha5, 1'b0, 1'b0);
      cmpFlag(acc.fileRead | acc.fileWrite, 1'b0);
      cmpFlag(acc.accWrite, 1'b1);
   endtask
   // Bit operations pick each of the eight bits.
   task automatic tBit();
      for (int b = 0; b < 8; b++) begin
         run(14'h1411 | 14'(b << 7), 8'h00, 8'hff, 1'b0, 1'b0);
         cmpVal(16'(fd.bitSel), 16'(b));
         cmpVal(16'(fd.fileIndex), 16'h0011);
      end
      // Tests of a set bit three: the clear test runs on, the set test skips.
      for (int s = 0; s < 2; s++) begin
         run(14'h1991 | 14'(s << 10), 8'h08, 8'h00, 1'b0, 1'b0);
         cmpFlag(flushNext, s[0]);
         cmpFlag(acc.fileRead & ~acc.fileWrite, 1'b1);
      end
   endtask
   // Literal loads with every setting of the ignored bits.
   task automatic tLit();
      for (int x = 0; x < 4; x++) begin
         run(14'h30a5 | 14'(x << 8), 8'h00, 8'h00, 1'b0, 1'b0);
         cmpVal(16'(fd.literal), 16'h00a5);
         cmpVal(16'(fd.opClass), 16'h0003);
         cmpFlag(acc.accWrite & ~acc.fileWrite, 1'b1);
         cmpFlag(flushNext, 1'b0);
      end
   endtask
   // Jump, then conditional skips and port read-back.
   task automatic tFlow();
      run(14'h2fff, 8'h00, 8'h00, 1'b0, 1'b0);
      cmpVal(16'(fd.jumpTarget), 16'h07ff);
      cmpFlag(acc.pcLoad & flushNext, 1'b1);
      cmpFlag(flushAcc.fileWrite | flushAcc.accWrite | flushAcc.pcLoad, 1'b0);
      for (int z = 0; z < 2; z++) begin
         run(14'h0ba0, 8'h01, 8'h00, 1'b0, z[0]);
         cmpFlag(flushNext, z[0]);
      end
      for (int q = 0; q < 2; q++) begin
         run(14'h0885, 8'h0f, 8'hf0, q[0], 1'b0);
         cmpVal(16'(rv), q ? 16'h00f0 : 16'h000f);
      end
      // Return with a literal, ignored bits set, then a plain return.
      run(14'h37a5, 8'h00, 8'h00, 1'b0, 1'b0);
      cmpVal(16'(fd.literal), 16'h00a5);
      cmpFlag(acc.accWrite & acc.pcReturn & flushNext, 1'b1);
      cmpFlag(flushAcc.accWrite | flushAcc.pcReturn, 1'b0);
      run(14'h0008, 8'h00, 8'h00, 1'b0, 1'b0);
      cmpFlag(acc.pcReturn & flushNext & ~acc.accWrite & ~acc.fileRead, 1'b1);
   endtask
   // Main sequence.
   initial begin
      repeat (8) @(posedge clk);
      reset_n <= 1'b1;
      tByte();
      tBit();
      tLit();
      tFlow();
      tally_and_finish();
   end
endmodule
